// ===== pkg/rcg_pkg.sv
package rcg_pkg;

    localparam logic [7:0] PCG_OFFSET        = 8'h64;
    localparam logic [7:0] PCG_RESET         = 8'h00;
    localparam int         BIT_TWO_WIRE      = 7;
    localparam int         BIT_TIMER_TWO     = 6;
    localparam int         BIT_TIMER_ZERO    = 5;
    localparam int         BIT_SERIAL_ONE    = 4;
    localparam int         BIT_TIMER_ONE     = 3;
    localparam int         BIT_SPI           = 2;
    localparam int         BIT_SERIAL_ZERO   = 1;
    localparam int         BIT_CONVERTER     = 0;
    localparam logic [7:0] CAUSE_OFFSET      = 8'h54;
    localparam logic [4:0] CAUSE_RESET       = 5'h00;
    localparam int         CAUSE_POWER_ON    = 0;
    localparam int         CAUSE_EXTERNAL    = 1;
    localparam int         CAUSE_BROWNOUT    = 2;
    localparam int         CAUSE_WATCHDOG    = 3;
    localparam int         CAUSE_SCAN        = 4;
    localparam int         STRETCH_W         = 20;
    localparam int         FILTER_W          = 4;
    localparam logic [FILTER_W-1:0] PIN_MIN_CYCLES = 4'h3;

    typedef struct packed {
        logic two_wire;
        logic timer_two;
        logic timer_zero;
        logic serial_one;
        logic timer_one;
        logic spi;
        logic serial_zero;
        logic converter;
    } rcg_gate_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcg_io_req_t;

endpackage : rcg_pkg

// ===== verilog/rcg_top.sv
// Functional notes
// RL1 - Bit 7 stops two-wire interface clock
// RL2 - Bit 6 stops timer two if synchronous
// RL3 - Bits 5,3 pause timers zero/one, state kept
// RL4 - Bits 4,1 stop serial one/zero clocks
// RL5 - Bit 2 stops SPI clock
// RL6 - Bit 0 shuts converter, blocks comparator mux
// RL7 - Software disables converter before setting bit 0
// RL8 - Reset returns I/O registers, fetch from vector
// RL9 - Ports forced at once, no clock needed
// RL10 - Stretch reset by fuse-chosen delay count
// RL11 - Power-on asserts immediately, count on recovery
// RL12 - Long reset pin low resets without clock
// RL13 - Disable fuse ignores reset pin
// RL14 - Brown-out resets at once when enabled
// RL15 - Watchdog resets only in reset mode
// RL16 - Watchdog one-cycle pulse, count after fall
// RL17 - Scan reset register holds reset while one
// RL18 - Watchdog flag set; cleared power-on or write
// RL19 - Power-on flag cleared only by write zero
// RL20 - Sources ORed; reassert restarts count
`timescale 1ns/100ps
`default_nettype none
module rcg_top
    import rcg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 power_low,
    input  wire logic                 reset_pin_n,
    input  wire logic                 reset_pin_disable_fuse,
    input  wire logic                 brownout_enable,
    input  wire logic                 brownout_low,
    input  wire logic                 watchdog_expire,
    input  wire logic                 watchdog_reset_mode,
    input  wire logic                 scan_reset_reg,
    input  wire logic [3:0]           startup_time_fuse,
    input  wire logic [3:0]           clock_select_fuse,
    input  wire logic                 timer_two_async_select,
    input  wire logic                 converter_mux_request,
    input  wire rcg_io_req_t          io_req,
    output logic [7:0]                io_rdata,
    output rcg_gate_t                 gate_enable,
    output logic                      comparator_mux_grant,
    output logic                      port_reset,
    output logic                      core_reset,
    output logic                      fetch_from_vector
);

    rcg_gate_t             peripheral_clock_gate;
    logic [4:0]            cause;
    logic                  pin_s1;
    logic                  pin_s2;
    logic                  bo_s1;
    logic                  bo_s2;
    logic                  scan_s1;
    logic                  scan_s2;
    logic [FILTER_W-1:0]   pin_low_cnt;
    logic                  pin_reset;
    logic                  wd_pulse;
    logic                  any_source;
    logic                  async_src;
    logic [STRETCH_W-1:0]  stretch_cnt;
    logic [STRETCH_W-1:0]  stretch_target;
    logic                  stretching;
    logic                  wr_gate;
    logic                  wr_cause;

    // Pin and scan levels force ports asynchronously, no clock needed
    assign async_src = power_low | scan_reset_reg
                     | (~reset_pin_n & ~reset_pin_disable_fuse)
                     | (brownout_enable & brownout_low); // RL9

    // Delay period from the fuses; each step doubles the stretch
    assign stretch_target = STRETCH_W'(1) << {1'b0, startup_time_fuse[1:0], clock_select_fuse[1:0]}; // RL10

    // Power-on acts as the async reset of the reset logic below and the cause flags; the gate register, read data and gate enables use rst
    always_ff @(posedge clk or posedge power_low) begin
        if (power_low) begin
            pin_s1  <= 1'b1;
            pin_s2  <= 1'b1;
            bo_s1   <= 1'b0;
            bo_s2   <= 1'b0;
            scan_s1 <= 1'b0;
            scan_s2 <= 1'b0;
        end else begin
            pin_s1  <= reset_pin_n;
            pin_s2  <= pin_s1;
            bo_s1   <= brownout_low;
            bo_s2   <= bo_s1;
            scan_s1 <= scan_reset_reg;
            scan_s2 <= scan_s1;
        end
    end

    // Short pin glitches are filtered; only long lows count
    always_ff @(posedge clk or posedge power_low) begin
        if (power_low) begin
            pin_low_cnt <= '0;
            pin_reset   <= 1'b0;
        end else if (pin_s2 || reset_pin_disable_fuse) begin // RL13
            pin_low_cnt <= '0;
            pin_reset   <= 1'b0;
        end else if (pin_low_cnt >= PIN_MIN_CYCLES) begin
            pin_reset   <= 1'b1; // RL12
        end else begin
            pin_low_cnt <= pin_low_cnt + FILTER_W'(1);
        end
    end

    // Watchdog pulse lasts exactly one clock
    always_ff @(posedge clk or posedge power_low) begin
        if (power_low) begin
            wd_pulse <= 1'b0;
        end else begin
            wd_pulse <= watchdog_expire & watchdog_reset_mode & ~wd_pulse; // RL15 RL16
        end
    end

    assign any_source = pin_reset | (brownout_enable & bo_s2) | wd_pulse | scan_s2; // RL20 RL14 RL17

    // Stretch counter restarts whenever any source is active
    always_ff @(posedge clk or posedge power_low) begin
        if (power_low) begin
            stretch_cnt <= '0; // RL11
            stretching  <= 1'b1;
        end else if (any_source) begin
            stretch_cnt <= '0; // RL20
            stretching  <= 1'b1;
        end else if (stretching) begin
            if (stretch_cnt >= stretch_target - STRETCH_W'(1)) begin
                stretching <= 1'b0; // RL10
            end else begin
                stretch_cnt <= stretch_cnt + STRETCH_W'(1); // RL16
            end
        end
    end

    // Port reset is a flop with async set, so it acts without clock
    always_ff @(posedge clk or posedge async_src) begin
        if (async_src) begin
            port_reset <= 1'b1; // RL9 RL11
        end else begin
            port_reset <= any_source | stretching;
        end
    end

    always_ff @(posedge clk or posedge power_low) begin
        if (power_low) begin
            core_reset        <= 1'b1;
            fetch_from_vector <= 1'b0;
        end else begin
            core_reset        <= any_source | stretching;
            fetch_from_vector <= core_reset & ~(any_source | stretching); // RL8
        end
    end

    assign wr_gate  = io_req.wr && (io_req.addr == PCG_OFFSET);
    assign wr_cause = io_req.wr && (io_req.addr == CAUSE_OFFSET);

    // Internal reset returns the register to its initial value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peripheral_clock_gate <= rcg_gate_t'(PCG_RESET);
        end else if (core_reset) begin
            peripheral_clock_gate <= rcg_gate_t'(PCG_RESET); // RL8
        end else if (wr_gate) begin
            peripheral_clock_gate <= rcg_gate_t'(io_req.wdata); // RL7
        end
    end

    // Cause flags survive all resets but power-on; set beats clear
    always_ff @(posedge clk or posedge power_low) begin
        if (power_low) begin
            cause <= 5'h01; // RL19
        end else begin
            cause[CAUSE_POWER_ON] <= cause[CAUSE_POWER_ON]
                                   & ~(wr_cause & ~io_req.wdata[CAUSE_POWER_ON]); // RL19
            cause[CAUSE_EXTERNAL] <= pin_reset
                                   | (cause[CAUSE_EXTERNAL] & ~(wr_cause & ~io_req.wdata[CAUSE_EXTERNAL]));
            cause[CAUSE_BROWNOUT] <= (brownout_enable & bo_s2)
                                   | (cause[CAUSE_BROWNOUT] & ~(wr_cause & ~io_req.wdata[CAUSE_BROWNOUT]));
            cause[CAUSE_WATCHDOG] <= wd_pulse
                                   | (cause[CAUSE_WATCHDOG] & ~(wr_cause & ~io_req.wdata[CAUSE_WATCHDOG])); // RL18
            cause[CAUSE_SCAN]     <= scan_s2
                                   | (cause[CAUSE_SCAN] & ~(wr_cause & ~io_req.wdata[CAUSE_SCAN]));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else if (io_req.rd && io_req.addr == PCG_OFFSET) begin
            io_rdata <= peripheral_clock_gate;
        end else if (io_req.rd && io_req.addr == CAUSE_OFFSET) begin
            io_rdata <= {3'h0, cause};
        end else begin
            io_rdata <= 8'h00;
        end
    end

    // Clock enables for gated peripherals; high means clock runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_enable          <= '1;
            comparator_mux_grant <= 1'b0;
        end else begin
            gate_enable.two_wire    <= ~peripheral_clock_gate.two_wire; // RL1
            // Async timer two runs from its own oscillator, left alone
            gate_enable.timer_two   <= ~(peripheral_clock_gate.timer_two & ~timer_two_async_select); // RL2
            gate_enable.timer_zero  <= ~peripheral_clock_gate.timer_zero; // RL3
            gate_enable.timer_one   <= ~peripheral_clock_gate.timer_one; // RL3
            gate_enable.serial_one  <= ~peripheral_clock_gate.serial_one; // RL4
            gate_enable.serial_zero <= ~peripheral_clock_gate.serial_zero; // RL4
            gate_enable.spi         <= ~peripheral_clock_gate.spi; // RL5
            gate_enable.converter   <= ~peripheral_clock_gate.converter; // RL6
            comparator_mux_grant    <= converter_mux_request & ~peripheral_clock_gate.converter; // RL6
        end
    end

endmodule : rcg_top
`default_nettype wire

// ===== sim/rcg_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcg_periph_model
    import rcg_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire rcg_gate_t gate_enable,
    output logic [7:0]     count
);
    // Gated timer keeps its count, no reload on wake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) count <= 8'h00;
        else if (gate_enable.timer_zero) count <= count + 8'h01;
    end
endmodule : rcg_periph_model
`default_nettype wire

// ===== sim/rcg_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rcg_asserts
    import rcg_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        power_low,
    input wire logic        reset_pin_n,
    input wire logic        reset_pin_disable_fuse,
    input wire logic        scan_reset_reg,
    input wire logic        watchdog_expire,
    input wire logic        watchdog_reset_mode,
    input wire logic        timer_two_async_select,
    input wire rcg_io_req_t io_req,
    input wire rcg_gate_t   gate_enable,
    input wire logic        comparator_mux_grant,
    input wire logic        port_reset,
    input wire logic        core_reset,
    input wire logic        fetch_from_vector
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_port_force: assert property ((power_low || scan_reset_reg || (!reset_pin_n && !reset_pin_disable_fuse))
        |-> port_reset) else $error("ports not forced");
    a_poweron_core: assert property (power_low |-> core_reset) else $error("power-on not in reset");
    a_scan_hold: assert property (scan_reset_reg [*4] |-> core_reset) else $error("scan reset not held");
    a_wdog_reset: assert property (!core_reset && watchdog_expire && watchdog_reset_mode
        |-> ##[1:4] core_reset) else $error("watchdog reset missing");
    a_fetch_pulse: assert property (fetch_from_vector |-> $past(core_reset) && !core_reset ##1 !fetch_from_vector)
        else $error("fetch pulse wrong");
    a_gate_write: assert property (io_req.wr && io_req.addr == PCG_OFFSET && !core_reset ##1 !io_req.wr && !core_reset
        |=> {gate_enable[7], gate_enable[5:0]} == ~{$past(io_req.wdata[7], 2), $past(io_req.wdata[5:0], 2)})
        else $error("gate bits wrong");
    a_timer_two: assert property (io_req.wr && io_req.addr == PCG_OFFSET && !core_reset ##1 !io_req.wr && !core_reset
        |=> gate_enable.timer_two == !($past(io_req.wdata[6], 2) && !$past(timer_two_async_select)))
        else $error("timer two gate wrong");
    a_mux_block: assert property (!gate_enable.converter |-> !comparator_mux_grant) else $error("mux granted");
    a_reset_clears: assert property (core_reset [*3] |-> gate_enable == 8'hFF) else $error("gates not reset");
endmodule : rcg_asserts
bind rcg_top rcg_asserts u_chk (.*);
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rcg_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, power_low = 1'b1, reset_pin_n = 1'b1, reset_pin_disable_fuse = 1'b0;
    logic        brownout_enable = 1'b0, brownout_low = 1'b0, watchdog_expire = 1'b0, watchdog_reset_mode = 1'b0;
    logic        scan_reset_reg = 1'b0, timer_two_async_select = 1'b0, converter_mux_request = 1'b0, rd_d = 1'b0;
    logic [3:0]  startup_time_fuse = 4'h0, clock_select_fuse = 4'h3;
    rcg_io_req_t io_req = '0;
    rcg_gate_t   gate_enable;
    logic [7:0]  io_rdata, count, v, exp_q[$];
    logic        comparator_mux_grant, port_reset, core_reset, fetch_from_vector;
    int          num_errors = 0, check_count = 0, k;
    rcg_top DUT (.*);
    rcg_periph_model u_model (.clk(clk), .rst(rst), .gate_enable(gate_enable), .count(count));
    always #50 clk = ~clk;
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_bit(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask : cmp_bit
    task automatic req(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        io_req <= '{w, r, a, d};
        @(posedge clk);
    endtask : req
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        req(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        io_req <= '0;
        repeat (n) @(posedge clk);
    endtask : idle
    // Bounded so a stuck reset cannot hang the run
    task automatic wait_fall();
        k = 0;
        while (core_reset !== 1'b0 && k < 300) begin
            @(posedge clk);
            k++;
        end
        cmp_bit(k < 300, 1'b1);
    endtask : wait_fall
    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        if (rd_d) cmp(io_rdata, exp_q.pop_front());
        rd_d <= io_req.rd;
    end
    initial begin
        #500000;
        num_errors++;
        close_out();
    end
    initial begin
        v = $urandom(32'h9399);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp_bit(port_reset, 1'b1);
        cmp_bit(core_reset, 1'b1);
        power_low <= 1'b0;
        wait_fall();
        cmp_bit(k >= 8 && k <= 12, 1'b1);
        rd(CAUSE_OFFSET, 8'h01);
        rd(PCG_OFFSET, PCG_RESET);
        rd(8'h55, 8'h00);
        for (int i = 0; i < 8; i++) begin
            req(1'b1, 1'b0, PCG_OFFSET, 8'h01 << i);
            idle(2);
            cmp(gate_enable, ~(8'h01 << i));
        end
        v = $urandom;
        req(1'b1, 1'b0, PCG_OFFSET, v);
        timer_two_async_select <= 1'b1;
        idle(3);
        cmp(gate_enable, ~v | 8'h40);
        rd(PCG_OFFSET, v);
        req(1'b1, 1'b0, PCG_OFFSET, 8'h20);
        timer_two_async_select <= 1'b0;
        idle(3);
        v = count;
        idle(5);
        cmp(count, v);
        req(1'b1, 1'b0, PCG_OFFSET, 8'h00);
        converter_mux_request <= 1'b1;
        idle(3);
        cmp_bit(count != v, 1'b1);
        cmp_bit(comparator_mux_grant, 1'b1);
        req(1'b1, 1'b0, PCG_OFFSET, 8'h01);
        idle(3);
        cmp_bit(comparator_mux_grant, 1'b0);
        reset_pin_n <= 1'b0;
        idle(1);
        cmp_bit(port_reset, 1'b1);
        idle(9);
        cmp_bit(core_reset, 1'b1);
        reset_pin_n <= 1'b1;
        wait_fall();
        rd(CAUSE_OFFSET, 8'h03);
        rd(PCG_OFFSET, 8'h00);
        req(1'b1, 1'b0, CAUSE_OFFSET, 8'h00);
        rd(CAUSE_OFFSET, 8'h00);
        reset_pin_disable_fuse <= 1'b1;
        reset_pin_n <= 1'b0;
        idle(12);
        cmp_bit(core_reset, 1'b0);
        cmp_bit(port_reset, 1'b0);
        reset_pin_n <= 1'b1;
        idle(6);
        reset_pin_disable_fuse <= 1'b0;
        watchdog_expire <= 1'b1;
        idle(1);
        watchdog_expire <= 1'b0;
        idle(6);
        cmp_bit(core_reset, 1'b0);
        watchdog_reset_mode <= 1'b1;
        watchdog_expire <= 1'b1;
        idle(1);
        watchdog_expire <= 1'b0;
        idle(4);
        cmp_bit(core_reset, 1'b1);
        wait_fall();
        rd(CAUSE_OFFSET, 8'h08);
        brownout_low <= 1'b1;
        idle(6);
        cmp_bit(core_reset, 1'b0);
        brownout_enable <= 1'b1;
        idle(6);
        cmp_bit(core_reset, 1'b1);
        brownout_low <= 1'b0;
        wait_fall();
        scan_reset_reg <= 1'b1;
        idle(40);
        cmp_bit(core_reset, 1'b1);
        scan_reset_reg <= 1'b0;
        idle(5);
        reset_pin_n <= 1'b0;
        idle(9);
        reset_pin_n <= 1'b1;
        idle(7);
        cmp_bit(core_reset, 1'b1);
        wait_fall();
        rd(CAUSE_OFFSET, 8'h1E);
        power_low <= 1'b1;
        idle(2);
        power_low <= 1'b0;
        wait_fall();
        rd(CAUSE_OFFSET, 8'h01);
        idle(3);
        close_out();
    end
endmodule : testbench
`default_nettype wire
